// ===== dv/malu_fabric_model.sv
// Fabric side model that accepts forwarding answers, promptly or after a stall
`timescale 1ns/10ps
`default_nettype none
module malu_fabric_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Answer handshake
  input wire logic fwd_valid,
  input wire logic [3:0] stall,
  output logic fwd_ready
);
  logic [3:0] wait_cnt;
  // Driven off the sampling edge so the take edge never races
  always_ff @(negedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fwd_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (!fwd_valid)
    begin
      fwd_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (wait_cnt >= stall)
      fwd_ready <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule
`default_nettype wire

// ===== dv/malu_lookup_chk.sv
// Port assertions of the address lookup engine
`timescale 1ns/10ps
`default_nettype none
module malu_lookup_chk #(
  parameter int NUM_PORTS = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Request
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire malu_pkg::malu_len_t rx_len,
  input wire logic rx_framing_err,
  input wire logic rx_fcs_err,
  input wire logic rx_align_err,
  input wire logic rx_pause,
  input wire logic [NUM_PORTS-1:0] stp_fwd_set,
  input wire logic [NUM_PORTS-1:0] igmp_port_set,
  input wire logic [NUM_PORTS-1:0] mirror_port_set,
  input wire logic [NUM_PORTS-1:0] port_vlan_set,
  // Answer
  input wire logic fwd_valid,
  input wire logic fwd_ready,
  input wire logic [NUM_PORTS-1:0] first_stage_port_set,
  input wire logic [NUM_PORTS-1:0] final_port_set,
  input wire logic fwd_drop,
  input wire logic fwd_local,
  input wire logic fwd_pause,
  input wire logic [1:0] fwd_src_port,
  // Gap
  input wire logic [NUM_PORTS-1:0] port_speed_100m,
  input wire logic [NUM_PORTS-1:0] tx_end_ok,
  input wire logic [NUM_PORTS-1:0] tx_collision,
  input wire logic [NUM_PORTS-1:0] tx_gap_ok
);
  import malu_pkg::*;

  // ********
  // Checks
  // ********
  logic take;
  logic rx_bad;
  assign take = rx_valid && rx_ready;
  // Length outside both legal ranges, whatever the large-frame select
  assign rx_bad = rx_framing_err | rx_fcs_err | rx_align_err | (rx_len < 11'h040) |
    (rx_len > 11'h7D0);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_lat;
    take |=> !rx_ready && !fwd_valid ##1 fwd_valid;
  endproperty
  a_lat: assert property (p_lat) else $error("answer latency wrong");
  property p_hold;
    fwd_valid && !fwd_ready |=> fwd_valid && $stable(final_port_set) && $stable(fwd_drop);
  endproperty
  a_hold: assert property (p_hold) else $error("answer not held");
  property p_err;
    take && rx_bad |-> ##2 fwd_drop && ~|final_port_set;
  endproperty
  a_err: assert property (p_err) else $error("bad frame forwarded");
  property p_pause;
    take && rx_pause |-> ##2 fwd_pause && fwd_drop && ~|final_port_set;
  endproperty
  a_pause: assert property (p_pause) else $error("pause frame forwarded");
  property p_local;
    fwd_valid && fwd_local |-> fwd_drop && ~|final_port_set;
  endproperty
  a_local: assert property (p_local) else $error("local frame forwarded");
  property p_nosrc;
    fwd_valid |-> !final_port_set[fwd_src_port];
  endproperty
  a_nosrc: assert property (p_nosrc) else $error("frame sent back to source");
  property p_stage2;
    $rose(fwd_valid) && !fwd_drop |-> final_port_set == (((first_stage_port_set &
      $past(stp_fwd_set) & $past(igmp_port_set)) | $past(mirror_port_set)) &
      $past(port_vlan_set) & ~(NUM_PORTS'(1) << fwd_src_port));
  endproperty
  a_stage2: assert property (p_stage2) else $error("final set wrong");
  property p_ipg;
    tx_end_ok[0] && port_speed_100m[0] && !tx_collision[0] |=>
      !tx_gap_ok[0] ##95 !tx_gap_ok[0] ##1 tx_gap_ok[0];
  endproperty
  a_ipg: assert property (p_ipg) else $error("gap length wrong");
  c_drop: cover property (take && rx_bad);
  c_local: cover property (fwd_valid && fwd_local);
  c_gap: cover property ($fell(tx_gap_ok[0]));
endmodule
bind malu_lookup_engine malu_lookup_chk #(.NUM_PORTS(NUM_PORTS)) i_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .rx_len(rx_len), .rx_framing_err(rx_framing_err), .rx_fcs_err(rx_fcs_err),
  .rx_align_err(rx_align_err), .rx_pause(rx_pause), .stp_fwd_set(stp_fwd_set),
  .igmp_port_set(igmp_port_set), .mirror_port_set(mirror_port_set),
  .port_vlan_set(port_vlan_set), .fwd_valid(fwd_valid), .fwd_ready(fwd_ready),
  .first_stage_port_set(first_stage_port_set), .final_port_set(final_port_set),
  .fwd_drop(fwd_drop), .fwd_local(fwd_local), .fwd_pause(fwd_pause),
  .fwd_src_port(fwd_src_port), .port_speed_100m(port_speed_100m),
  .tx_end_ok(tx_end_ok), .tx_collision(tx_collision), .tx_gap_ok(tx_gap_ok));
`default_nettype wire

// ===== dv/malu_lookup_engine_tb.sv
// Self-checking bench of the address lookup engine
`timescale 1ns/10ps
`default_nettype none
module malu_lookup_engine_tb;
  import malu_pkg::*;
  localparam int NP = 3;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] ctl = 16'h0000;
  logic big = 1'b0;
  logic rx_valid = 1'b0;
  logic rx_ready, fwd_valid, fwd_ready, fwd_drop, fwd_local, fwd_pause, table_full;
  logic [1:0] rx_port = 2'h0;
  logic [1:0] src;
  malu_mac_t rx_sa = 48'h0;
  malu_mac_t rx_da = 48'h0;
  malu_len_t rx_len = 11'h040;
  logic [3:0] err = 4'h0;
  logic st_hit = 1'b0;
  logic [NP-1:0] st_set = 3'h0, vlan = 3'h7, stp = 3'h7, igmp = 3'h7, mirror = 3'h0;
  logic [NP-1:0] pvlan = 3'h7, first, fin, tx_gap_ok;
  logic [NP-1:0] speed = 3'h7, end_ok = 3'h0, coll = 3'h0, crs = 3'h0;
  logic [3:0] stall = 4'h0;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  localparam logic [15:0] ALL = 16'h01FF;
  localparam logic [15:0] DRP = 16'h003F;

  // ********
  // Harness
  // ********
  malu_lookup_engine #(.ENTRIES(4), .NUM_PORTS(NP), .AGE_EPOCH_CYCLES(50)) i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .global_switch_control_one(ctl), .big_frame_en(big),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_port(rx_port), .rx_sa(rx_sa),
    .rx_da(rx_da), .rx_vid(12'h001), .rx_len(rx_len), .rx_framing_err(err[0]),
    .rx_fcs_err(err[1]), .rx_align_err(err[2]), .rx_pause(err[3]), .static_hit(st_hit),
    .static_port_set(st_set), .vlan_member_set(vlan), .stp_fwd_set(stp),
    .igmp_port_set(igmp), .mirror_port_set(mirror), .port_vlan_set(pvlan),
    .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .first_stage_port_set(first),
    .final_port_set(fin), .fwd_drop(fwd_drop), .fwd_local(fwd_local),
    .fwd_pause(fwd_pause), .fwd_src_port(src), .table_full(table_full),
    .port_speed_100m(speed), .tx_end_ok(end_ok), .tx_collision(coll), .tx_crs(crs),
    .tx_gap_ok(tx_gap_ok));
  malu_fabric_model i_fab (.ref_clk(ref_clk), .rst_b(rst_b), .fwd_valid(fwd_valid),
    .stall(stall), .fwd_ready(fwd_ready));

  always #5 ref_clk = ~ref_clk;

  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      $display("unexpected run length: expected below 20000, seen %0d", cycles);
      give_verdict();
    end
  end

  function automatic logic [15:0] fx(input logic [2:0] f1, f2, dlp);
    return {7'h00, f1, f2, dlp};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Called at a falling edge; the request is held until its take edge has passed
  task automatic look(input logic [1:0] p, input malu_mac_t sa, da, input malu_len_t len,
      input logic [3:0] e, input logic [15:0] exp, msk);
    int n;
    rx_port = p;
    rx_sa = sa;
    rx_da = da;
    rx_len = len;
    err = e;
    rx_valid = 1'b1;
    @(negedge ref_clk);
    rx_valid = 1'b0;
    n = 0;
    while (fwd_valid !== 1'b1 && n < 8)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("answer", exp & msk, {7'h00, first, fin, fwd_drop, fwd_local, fwd_pause} & msk);
    chk("source port", {14'h0000, p}, {14'h0000, src});
    n = 0;
    while (fwd_valid !== 1'b0 && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  // ********
  // Scenarios
  // ********
  task automatic s_learn();
    look(1, 48'hA1, 48'hB2, 11'h040, 4'h0, fx(3'h7, 3'h5, 3'h0), ALL);
    look(2, 48'hB2, 48'hA1, 11'h064, 4'h0, fx(3'h2, 3'h2, 3'h0), ALL);
  endtask

  task automatic s_stage();
    st_hit = 1'b1;
    st_set = 3'h3;
    vlan = 3'h6;
    igmp = 3'h5;
    mirror = 3'h4;
    look(1, 48'hA1, 48'hEE, 11'h040, 4'h0, fx(3'h2, 3'h4, 3'h0), ALL);
    st_hit = 1'b0;
    vlan = 3'h7;
    igmp = 3'h7;
    mirror = 3'h0;
  endtask

  task automatic s_migrate();
    stall = 4'h2;
    look(0, 48'hA1, 48'hB2, 11'h600, 4'h0, fx(3'h4, 3'h4, 3'h0), ALL);
    look(2, 48'hB2, 48'hA1, 11'h040, 4'h0, fx(3'h1, 3'h1, 3'h0), ALL);
    look(2, 48'hA1, 48'hA1, 11'h040, 4'h2, fx(3'h0, 3'h0, 3'h4), DRP);
    look(1, 48'hB2, 48'hA1, 11'h040, 4'h0, fx(3'h1, 3'h1, 3'h0), ALL);
    stall = 4'h0;
    look(0, 48'hA1, 48'hA1, 11'h040, 4'h0, fx(3'h0, 3'h0, 3'h6), DRP);
  endtask

  task automatic s_errors();
    for (int i = 0; i < 5; i++)
      look(1, 48'hC3, 48'hA1, (i == 3) ? 11'h03F : (i == 4) ? 11'h601 : 11'h040,
        (i < 3) ? (4'h1 << i) : 4'h0, fx(3'h0, 3'h0, 3'h4), DRP);
    look(1, 48'hB2, 48'hC3, 11'h040, 4'h0, fx(3'h7, 3'h5, 3'h0), ALL);
    look(0, 48'hA1, 48'hB2, 11'h040, 4'h8, fx(3'h0, 3'h0, 3'h5), DRP);
    big = 1'b1;
    look(0, 48'hA1, 48'hB2, 11'h7D0, 4'h0, fx(3'h2, 3'h2, 3'h0), ALL);
    look(0, 48'hA1, 48'hB2, 11'h7D1, 4'h0, fx(3'h0, 3'h0, 3'h4), DRP);
    big = 1'b0;
  endtask

  task automatic s_full();
    look(2, 48'hE5, 48'hEE, 11'h040, 4'h0, fx(3'h7, 3'h3, 3'h0), ALL);
    look(2, 48'hF6, 48'hEE, 11'h040, 4'h0, fx(3'h7, 3'h3, 3'h0), ALL);
    chk("table full", 16'h0001, {15'h0000, table_full});
    look(1, 48'h97, 48'hEE, 11'h040, 4'h0, fx(3'h7, 3'h5, 3'h0), ALL);
    look(1, 48'h97, 48'h97, 11'h040, 4'h0, fx(3'h0, 3'h0, 3'h6), DRP);
    chk("table full", 16'h0001, {15'h0000, table_full});
  endtask

  task automatic s_aging();
    repeat (400) @(negedge ref_clk);
    look(1, 48'h97, 48'h97, 11'h040, 4'h0, fx(3'h0, 3'h0, 3'h6), DRP);
    ctl = 16'h0400;
    repeat (5)
    begin
      repeat (100) @(negedge ref_clk);
      look(1, 48'h97, 48'h97, 11'h040, 4'h0, fx(3'h0, 3'h0, 3'h6), DRP);
    end
    repeat (400) @(negedge ref_clk);
    look(1, 48'h97, 48'h97, 11'h040, 4'h0, fx(3'h7, 3'h5, 3'h0), ALL);
  endtask

  // Collision case keeps carrier up for a while; the gap must count from its drop
  task automatic gap(input int p, input logic s100, cl, input int exp);
    int n;
    speed[p] = s100;
    if (cl)
    begin
      coll[p] = 1'b1;
      crs[p] = 1'b1;
      @(negedge ref_clk);
      coll[p] = 1'b0;
      repeat (20) @(negedge ref_clk);
      crs[p] = 1'b0;
    end
    else
      end_ok[p] = 1'b1;
    @(negedge ref_clk);
    end_ok[p] = 1'b0;
    n = 0;
    while (tx_gap_ok[p] === 1'b0 && n < 2000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("gap cycles", exp[15:0], n[15:0]);
  endtask

  initial
  begin
    repeat (10) @(negedge ref_clk);
    chk("reset state", 16'h0027, {10'h000, rx_ready, fwd_valid, table_full, tx_gap_ok});
    rst_b = 1'b1;
    @(negedge ref_clk);
    s_learn();
    s_stage();
    s_migrate();
    s_errors();
    s_full();
    s_aging();
    gap(0, 1'b1, 1'b0, 96);
    gap(1, 1'b0, 1'b0, 960);
    gap(2, 1'b1, 1'b1, 96);
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== rtl/malu_cfg.svh
// Constants of the address lookup engine: offsets of time, sizes and counts
// Operation
// - The table holds 1K unicast entries and, being fully associative, learns all of them.
// - A new entry is made only for an absent source address on an error-free, legal-length frame.
// - A learned entry stores the source address, the ingress port and the current time stamp.
// - With the table full, the oldest entry of the last full sweep pass is evicted and the new address takes its slot.
// - A known address seen on another port, error-free and legal length, gets the new port.
// - Every sighting of a stored source address refreshes that entry's time stamp.
// - A background sweep removes entries not refreshed for about 300 s, within 75 s.
// - The aging enable, bit 10 of the global switch control, stops removal when cleared.
// - Stage one resolves the destination via VLAN, static and dynamic tables to a port set.
// - Stage two trims that set by spanning tree and IGMP, adds the mirror ports, trims by port VLAN, then sends it.
// - Frames with framing, FCS, alignment or size errors are never forwarded.
// - PAUSE frames are consumed for flow control and forwarded to no port.
// - A unicast frame whose destination is learned on its own ingress port (no static hit) is local and dropped.
// - After a good transmission the port waits at least 96 bit times before the next packet.
// - After collisions the 96 bit time gap is measured from the end of carrier sense.
// - A legal length is 64 bytes up to 1536, or up to 2000 when large frames are enabled.
`ifndef MALU_CFG_SVH
`define MALU_CFG_SVH

`define MALU_ENTRIES 1024
`define MALU_NUM_PORTS 3
`define MALU_AGING_EN_BIT 10
`define MALU_MIN_LEN 11'h040
`define MALU_MAX_LEN 11'h600
`define MALU_MAX_LEN_BIG 11'h7D0
`define MALU_CLK_PERIOD_PS 10000
`define MALU_AGE_PERIOD_S 300
`define MALU_AGE_TOL_S 75
`define MALU_AGE_EPOCHS (`MALU_AGE_PERIOD_S / `MALU_AGE_TOL_S)
`define MALU_AGE_EPOCH_CYCLES \
  (64'd1000000000000 * `MALU_AGE_TOL_S / `MALU_CLK_PERIOD_PS)
`define MALU_IPG_BITS 96
`define MALU_BIT_PS_100M 10000
`define MALU_BIT_PS_10M 100000
`define MALU_IPG_CYC_100M \
  ((`MALU_IPG_BITS * `MALU_BIT_PS_100M + `MALU_CLK_PERIOD_PS - 1) / `MALU_CLK_PERIOD_PS)
`define MALU_IPG_CYC_10M \
  ((`MALU_IPG_BITS * `MALU_BIT_PS_10M + `MALU_CLK_PERIOD_PS - 1) / `MALU_CLK_PERIOD_PS)

`endif

// ===== rtl/malu_ipg_timer.sv
// Per-port inter-packet gap timer
`timescale 1ns/10ps
`default_nettype none
`include "malu_cfg.svh"
module malu_ipg_timer #(
  parameter int CNT_W = 10
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Port state
  input wire logic speed_100m,
  input wire logic tx_end_ok,
  input wire logic tx_collision,
  input wire logic crs,
  // Gap status
  output logic gap_ok
);
  localparam logic [CNT_W-1:0] CYC_100M = CNT_W'(`MALU_IPG_CYC_100M);
  localparam logic [CNT_W-1:0] CYC_10M = CNT_W'(`MALU_IPG_CYC_10M);

  logic [CNT_W-1:0] gap_cnt;
  logic coll_pend;
  logic start_gap;

  // Collided packet: gap starts only when carrier drops
  assign start_gap = tx_end_ok || (coll_pend && !crs && !tx_collision);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      coll_pend <= 1'b0;
    else if (tx_collision)
      coll_pend <= 1'b1;
    else if (start_gap)
      coll_pend <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      gap_cnt <= '0;
    else if (start_gap)
      gap_cnt <= speed_100m ? CYC_100M : CYC_10M;
    else if (gap_cnt != '0)
      gap_cnt <= gap_cnt - CNT_W'(1);
  end

  assign gap_ok = (gap_cnt == '0) && !coll_pend;
endmodule
`default_nettype wire

// ===== rtl/malu_lookup_engine.sv
// Address lookup engine: learning, migration, aging, forwarding, IPG
`timescale 1ns/10ps
`default_nettype none
`include "malu_cfg.svh"
module malu_lookup_engine #(
  parameter int ENTRIES = `MALU_ENTRIES,
  parameter int NUM_PORTS = `MALU_NUM_PORTS,
  parameter longint AGE_EPOCH_CYCLES = `MALU_AGE_EPOCH_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Global control
  input wire logic [15:0] global_switch_control_one,
  input wire logic big_frame_en,
  // Received frame request
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [1:0] rx_port,
  input wire malu_pkg::malu_mac_t rx_sa,
  input wire malu_pkg::malu_mac_t rx_da,
  input wire malu_pkg::malu_vid_t rx_vid,
  input wire malu_pkg::malu_len_t rx_len,
  input wire logic rx_framing_err,
  input wire logic rx_fcs_err,
  input wire logic rx_align_err,
  input wire logic rx_pause,
  // Static table and VLAN answers, given with the request
  input wire logic static_hit,
  input wire logic [NUM_PORTS-1:0] static_port_set,
  input wire logic [NUM_PORTS-1:0] vlan_member_set,
  // Stage two masks
  input wire logic [NUM_PORTS-1:0] stp_fwd_set,
  input wire logic [NUM_PORTS-1:0] igmp_port_set,
  input wire logic [NUM_PORTS-1:0] mirror_port_set,
  input wire logic [NUM_PORTS-1:0] port_vlan_set,
  // Forwarding answer
  output logic fwd_valid,
  input wire logic fwd_ready,
  output logic [NUM_PORTS-1:0] first_stage_port_set,
  output logic [NUM_PORTS-1:0] final_port_set,
  output logic fwd_drop,
  output logic fwd_local,
  output logic fwd_pause,
  output logic [1:0] fwd_src_port,
  output logic table_full,
  // Transmit gap per port
  input wire logic [NUM_PORTS-1:0] port_speed_100m,
  input wire logic [NUM_PORTS-1:0] tx_end_ok,
  input wire logic [NUM_PORTS-1:0] tx_collision,
  input wire logic [NUM_PORTS-1:0] tx_crs,
  output logic [NUM_PORTS-1:0] tx_gap_ok
);
  import malu_pkg::*;

  localparam int IW = $clog2(ENTRIES);
  localparam logic [IW-1:0] LAST_IDX = IW'(ENTRIES - 1);
  localparam malu_stamp_t AGE_EPOCHS = malu_stamp_t'(`MALU_AGE_EPOCHS);

  // ****************************************************************
  // Table storage and request capture
  // ****************************************************************
  malu_mac_t tab_mac [ENTRIES];
  logic [1:0] tab_port [ENTRIES];
  malu_stamp_t tab_stamp [ENTRIES];
  logic [ENTRIES-1:0] tab_valid;

  malu_state_t state;
  logic [1:0] src_q;
  malu_mac_t sa_q;
  malu_mac_t da_q;
  malu_len_t len_q;
  logic err_q;
  logic pause_q;
  logic static_hit_q;
  logic [NUM_PORTS-1:0] static_set_q;
  logic [NUM_PORTS-1:0] vlan_set_q;

  logic rx_take;
  assign rx_ready = (state == MALU_IDLE);
  assign rx_take = rx_valid && rx_ready;
  assign fwd_valid = (state == MALU_SEND);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= MALU_IDLE;
    else
    begin
      unique case (state)
        MALU_IDLE: if (rx_take) state <= MALU_LOOK;
        MALU_LOOK: state <= MALU_SEND;
        MALU_SEND: if (fwd_ready) state <= MALU_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      src_q <= 2'h0;
      sa_q <= '0;
      da_q <= '0;
      len_q <= '0;
      err_q <= 1'b0;
      pause_q <= 1'b0;
      static_hit_q <= 1'b0;
      static_set_q <= '0;
      vlan_set_q <= '0;
    end
    else if (rx_take)
    begin
      src_q <= rx_port;
      sa_q <= rx_sa;
      da_q <= rx_da;
      len_q <= rx_len;
      err_q <= rx_framing_err || rx_fcs_err || rx_align_err;
      pause_q <= rx_pause;
      static_hit_q <= static_hit;
      static_set_q <= static_port_set;
      vlan_set_q <= vlan_member_set;
    end
  end

  // ****************************************************************
  // Parallel match: no hashing, so every entry is usable
  // ****************************************************************
  logic [ENTRIES-1:0] sa_hit_vec;
  logic [ENTRIES-1:0] da_hit_vec;

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++)
    begin : g_cmp
      assign sa_hit_vec[g] = tab_valid[g] && (tab_mac[g] == sa_q);
      assign da_hit_vec[g] = tab_valid[g] && (tab_mac[g] == da_q);
    end
  endgenerate

  function automatic logic [IW-1:0] first_set(input logic [ENTRIES-1:0] vec);
    logic [IW-1:0] idx;
    idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--)
      if (vec[i])
        idx = IW'(i);
    return idx;
  endfunction

  logic sa_hit;
  logic da_hit;
  logic [IW-1:0] sa_idx;
  logic [IW-1:0] da_idx;
  logic [IW-1:0] free_idx;
  assign sa_hit = |sa_hit_vec;
  assign da_hit = |da_hit_vec;
  assign sa_idx = first_set(sa_hit_vec);
  assign da_idx = first_set(da_hit_vec);
  assign free_idx = first_set(~tab_valid);
  assign table_full = &tab_valid;

  // ****************************************************************
  // Aging clock: epochs of the tolerance, entries age out at four
  // ****************************************************************
  logic [63:0] epoch_cnt;
  malu_stamp_t epoch;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      epoch_cnt <= 64'h0;
    else if (epoch_cnt == 64'(AGE_EPOCH_CYCLES - 1))
      epoch_cnt <= 64'h0;
    else
      epoch_cnt <= epoch_cnt + 64'h1;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      epoch <= '0;
    else if (epoch_cnt == 64'(AGE_EPOCH_CYCLES - 1))
      epoch <= epoch + malu_stamp_t'(1);
  end

  // ****************************************************************
  // Learning, migration and refresh
  // ****************************************************************
  logic len_ok;
  logic frame_ok;
  logic do_learn;
  logic do_migrate;
  logic do_write;
  logic [IW-1:0] wr_idx;
  logic [IW-1:0] victim_idx;

  assign len_ok = (len_q >= `MALU_MIN_LEN) &&
                  (len_q <= (big_frame_en ? `MALU_MAX_LEN_BIG : `MALU_MAX_LEN));
  assign frame_ok = !err_q && len_ok;
  assign do_learn = (state == MALU_LOOK) && frame_ok && !sa_hit;
  assign do_migrate = (state == MALU_LOOK) && frame_ok && sa_hit &&
                      (tab_port[sa_idx] != src_q);
  assign do_write = do_learn || ((state == MALU_LOOK) && sa_hit);
  assign wr_idx = sa_hit ? sa_idx : (table_full ? victim_idx : free_idx);

  // Wide payload carries no reset; valid bits guard it
  always_ff @(posedge ref_clk)
  begin
    if (do_learn)
      tab_mac[wr_idx] <= sa_q;
    if (do_learn || do_migrate)
      tab_port[wr_idx] <= src_q;
    if (do_write)
      tab_stamp[wr_idx] <= epoch;
  end

  // ****************************************************************
  // Background sweep: removal and oldest-entry tracking
  // ****************************************************************
  logic [IW-1:0] sweep_idx;
  malu_stamp_t sweep_age;
  logic sweep_stale;
  logic [IW-1:0] cand_idx;
  malu_stamp_t cand_age;
  logic cand_beat;

  assign sweep_age = epoch - tab_stamp[sweep_idx];
  assign sweep_stale = tab_valid[sweep_idx] && (sweep_age >= AGE_EPOCHS);
  assign cand_beat = tab_valid[sweep_idx] && (sweep_age >= cand_age);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      sweep_idx <= '0;
    else
      sweep_idx <= (sweep_idx == LAST_IDX) ? '0 : sweep_idx + IW'(1);
  end

  // Victim is the oldest of the last full pass; a refresh since then
  // may leave it slightly younger than the true oldest
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cand_idx <= '0;
      cand_age <= '0;
      victim_idx <= '0;
    end
    else if (sweep_idx == LAST_IDX)
    begin
      victim_idx <= cand_beat ? sweep_idx : cand_idx;
      cand_idx <= '0;
      cand_age <= '0;
    end
    else if (cand_beat)
    begin
      cand_idx <= sweep_idx;
      cand_age <= sweep_age;
    end
  end

  // Frame update wins over removal of the same slot
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      tab_valid <= '0;
    else
    begin
      if (global_switch_control_one[`MALU_AGING_EN_BIT] && sweep_stale &&
          !(do_write && (wr_idx == sweep_idx)))
        tab_valid[sweep_idx] <= 1'b0;
      if (do_learn)
        tab_valid[wr_idx] <= 1'b1;
    end
  end

  // ****************************************************************
  // Two-stage destination resolution
  // ****************************************************************
  logic [NUM_PORTS-1:0] src_onehot;
  logic [NUM_PORTS-1:0] dyn_onehot;
  logic [NUM_PORTS-1:0] next_first;
  logic [NUM_PORTS-1:0] next_final;
  logic next_local;
  logic next_drop;

  assign src_onehot = NUM_PORTS'(1) << src_q;
  assign dyn_onehot = NUM_PORTS'(1) << tab_port[da_idx];

  always_comb
  begin
    if (da_q[40])
      next_first = '1;
    else if (static_hit_q)
      next_first = static_set_q;
    else if (da_hit)
      next_first = dyn_onehot;
    else
      next_first = '1;
    next_first = next_first & vlan_set_q;
    next_local = !da_q[40] && !static_hit_q && da_hit &&
                 (tab_port[da_idx] == src_q);
    next_drop = err_q || !len_ok || pause_q || next_local;
    next_final = ((next_first & stp_fwd_set & igmp_port_set) | mirror_port_set) &
                 port_vlan_set & ~src_onehot;
    if (next_drop)
      next_final = '0;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      first_stage_port_set <= '0;
      final_port_set <= '0;
      fwd_drop <= 1'b0;
      fwd_local <= 1'b0;
      fwd_pause <= 1'b0;
      fwd_src_port <= 2'h0;
    end
    else if (state == MALU_LOOK)
    begin
      first_stage_port_set <= next_first;
      final_port_set <= next_final;
      fwd_drop <= next_drop;
      fwd_local <= next_local;
      fwd_pause <= pause_q;
      fwd_src_port <= src_q;
    end
  end

  // ****************************************************************
  // Transmit gap timers
  // ****************************************************************
  generate
    for (g = 0; g < NUM_PORTS; g++)
    begin : g_ipg
      malu_ipg_timer #(.CNT_W(10)) u_ipg (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .speed_100m(port_speed_100m[g]),
        .tx_end_ok(tx_end_ok[g]),
        .tx_collision(tx_collision[g]),
        .crs(tx_crs[g]),
        .gap_ok(tx_gap_ok[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ===== rtl/malu_pkg.sv
// Types shared by the address lookup engine
package malu_pkg;
  typedef logic [47:0] malu_mac_t;
  typedef logic [11:0] malu_vid_t;
  typedef logic [10:0] malu_len_t;
  typedef logic [2:0] malu_stamp_t;
  typedef enum logic [1:0] {MALU_IDLE, MALU_LOOK, MALU_SEND} malu_state_t;
endpackage
